// *** design/sers_read_slave.sv ***
`timescale 1ns/10ps
module sers_read_slave
  import sers_pkg::*;
#(
  parameter int ADDR_W = DEF_ADDR_W
) (
  input wire logic clk, // System clock
  input wire logic srst, // Synchronous reset
  input wire logic scl_i, // Serial clock pin
  input wire logic sda_i, // Serial data pin level
  output logic sda_o, // Serial data drive value
  output logic sda_oe, // Serial data pull-low enable
  input wire logic supply_low, // Supply below trip level
  input wire logic prog_busy, // Programming cycle running
  input wire logic mem_we, // Array write strobe
  input wire logic [ADDR_W-1:0] mem_waddr, // Array write address
  input wire logic [7:0] mem_wdata, // Array write data
  output logic rd_active, // Slave is transmitting a read
  output logic [ADDR_W-1:0] addr_ptr // Current address counter
);
  localparam int DEPTH = 1 << ADDR_W;

  // Refused at elaboration: the pointer is loaded from one address byte
  if (ADDR_W < 1 || ADDR_W > 8) begin : g_bad_addr_w
    $error("ADDR_W must be 1 to 8");
  end

  typedef struct packed {
    logic scl1;
    logic scl2;
    logic scl3;
    logic sda1;
    logic sda2;
    logic sda3;
    logic low1;
    logic low2;
    logic busy1;
    logic busy2;
    sers_state_e state;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic mack;
    logic sda_o;
    logic sda_oe;
    logic [ADDR_W-1:0] ptr;
    logic [ADDR_W-1:0] fptr;
    logic [1:0][7:0] bdat;
    logic bhead;
    logic [1:0] bcnt;
    logic rd_act;
  } sers_st_s;

  sers_st_s st_r;
  sers_st_s st_nxt;
  logic [7:0] mem [DEPTH];

  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic pop;
  logic push;
  logic flush;
  logic [ADDR_W-1:0] flush_addr;
  logic widx;
  logic [7:0] head_byte;

  // Edges use the second and third stages only
  assign scl_rise = st_r.scl2 & ~st_r.scl3;
  assign scl_fall = ~st_r.scl2 & st_r.scl3;
  assign start_c = st_r.scl2 & st_r.scl3 & ~st_r.sda2 & st_r.sda3;
  assign stop_c = st_r.scl2 & st_r.scl3 & st_r.sda2 & ~st_r.sda3;
  assign head_byte = st_r.bdat[st_r.bhead];

  always_comb begin
    st_nxt = st_r;
    pop = 1'b0;
    flush = 1'b0;
    flush_addr = st_r.ptr;
    st_nxt.scl1 = scl_i;
    st_nxt.scl2 = st_r.scl1;
    st_nxt.scl3 = st_r.scl2;
    st_nxt.sda1 = sda_i;
    st_nxt.sda2 = st_r.sda1;
    st_nxt.sda3 = st_r.sda2;
    st_nxt.low1 = supply_low;
    st_nxt.low2 = st_r.low1;
    st_nxt.busy1 = prog_busy;
    st_nxt.busy2 = st_r.busy1;
    if (start_c) begin
      // Repeated start keeps the pointer; prefetch restarts from it
      st_nxt.state = ST_RX_CTRL;
      st_nxt.bitcnt = '0;
      st_nxt.sda_oe = 1'b0;
      flush = 1'b1;
    end else if (stop_c) begin
      st_nxt.state = ST_IDLE;
      st_nxt.sda_oe = 1'b0;
    end else begin
      unique case (st_r.state)
        ST_IDLE, ST_IGNORE: begin
          st_nxt.sda_oe = 1'b0;
        end
        ST_RX_CTRL, ST_RX_WADDR: begin
          if (scl_rise && st_r.bitcnt < BITS_RX) begin
            st_nxt.shreg = {st_r.shreg[6:0], st_r.sda2};
            st_nxt.bitcnt = st_r.bitcnt + 4'h1;
          end else if (scl_fall && st_r.bitcnt == BITS_RX) begin
            st_nxt.bitcnt = '0;
            if (st_r.busy2) begin
              st_nxt.state = ST_IGNORE;
            end else if (st_r.state == ST_RX_WADDR) begin
              st_nxt.ptr = st_r.shreg[ADDR_W-1:0];
              flush = 1'b1;
              flush_addr = st_r.shreg[ADDR_W-1:0];
              st_nxt.sda_oe = 1'b1;
              st_nxt.state = ST_ACK_WADDR;
            end else if (st_r.shreg[CODE_MSB:CODE_LSB] == DEV_CODE) begin
              st_nxt.sda_oe = 1'b1;
              st_nxt.state = ST_ACK_CTRL;
            end else begin
              st_nxt.state = ST_IGNORE;
            end
          end
        end
        ST_ACK_CTRL: begin
          if (scl_fall) begin
            if (st_r.shreg[RW_BIT]) begin
              // First data bit goes out on the fall that ends the ack
              pop = 1'b1;
              st_nxt.shreg = head_byte;
              st_nxt.sda_oe = ~head_byte[7];
              st_nxt.ptr = st_r.ptr + 1'b1;
              st_nxt.state = ST_TX;
            end else begin
              st_nxt.sda_oe = 1'b0;
              st_nxt.state = ST_RX_WADDR;
            end
          end
        end
        ST_ACK_WADDR: begin
          // Data bytes of a write are outside this block
          if (scl_fall) begin
            st_nxt.sda_oe = 1'b0;
            st_nxt.state = ST_IGNORE;
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (st_r.bitcnt == LAST_TX_SHIFT) begin
              st_nxt.sda_oe = 1'b0;
              st_nxt.bitcnt = '0;
              st_nxt.state = ST_RACK;
            end else begin
              st_nxt.shreg = {st_r.shreg[6:0], 1'b0};
              st_nxt.sda_oe = ~st_r.shreg[6];
              st_nxt.bitcnt = st_r.bitcnt + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            st_nxt.mack = ~st_r.sda2;
          end else if (scl_fall) begin
            if (st_r.mack && st_r.bcnt != 2'h0 && !st_r.busy2) begin
              pop = 1'b1;
              st_nxt.shreg = head_byte;
              st_nxt.sda_oe = ~head_byte[7];
              st_nxt.ptr = st_r.ptr + 1'b1;
              st_nxt.state = ST_TX;
            end else begin
              st_nxt.sda_oe = 1'b0;
              st_nxt.state = ST_IDLE;
            end
          end
        end
      endcase
    end
    // Registered so the status output comes straight from a flip-flop
    st_nxt.rd_act = (st_nxt.state == ST_TX) || (st_nxt.state == ST_RACK);
    // Two-entry prefetch buffer between array and shifter; shifter stalls it
    push = (st_r.bcnt != 2'h2);
    widx = st_r.bhead ^ st_r.bcnt[0];
    if (flush) begin
      st_nxt.bcnt = '0;
      st_nxt.fptr = flush_addr;
    end else begin
      st_nxt.bhead = st_r.bhead ^ pop;
      st_nxt.bcnt = st_r.bcnt + {1'b0, push} - {1'b0, pop};
      if (push) begin
        st_nxt.bdat[widx] = mem[st_r.fptr];
        st_nxt.fptr = st_r.fptr + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
      st_r.scl1 <= 1'b1;
      st_r.scl2 <= 1'b1;
      st_r.scl3 <= 1'b1;
      st_r.sda1 <= 1'b1;
      st_r.sda2 <= 1'b1;
      st_r.sda3 <= 1'b1;
      st_r.state <= ST_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Array load is refused while supply is low
  always_ff @(posedge clk) begin
    if (mem_we && !st_r.low2) begin
      mem[mem_waddr] <= mem_wdata;
    end
  end

  assign sda_o = st_r.sda_o;
  assign sda_oe = st_r.sda_oe;
  assign rd_active = st_r.rd_act;
  assign addr_ptr = st_r.ptr;
endmodule

// *** design/sers_pkg.sv ***
package sers_pkg;
  localparam logic [3:0] DEV_CODE = 4'ha;
  localparam int CODE_MSB = 7;
  localparam int CODE_LSB = 4;
  localparam int RW_BIT = 0;
  localparam logic [3:0] BITS_RX = 4'h8;
  localparam logic [3:0] LAST_TX_SHIFT = 4'h7;
  localparam int DEF_ADDR_W = 8;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX_CTRL,
    ST_ACK_CTRL,
    ST_RX_WADDR,
    ST_ACK_WADDR,
    ST_TX,
    ST_RACK,
    ST_IGNORE
  } sers_state_e;
endpackage

// *** tb/sers_read_slave_asserts.sv ***
`timescale 1ns/10ps
module sers_read_slave_asserts #(parameter int ADDR_W = 8) (
  input wire logic clk, // Clock
  input wire logic srst, // Reset
  input wire logic scl_i, // Bus clock
  input wire logic sda_i, // Data wire
  input wire logic sda_o, // Drive value
  input wire logic sda_oe, // Pull enable
  input wire logic prog_busy, // Programming
  input wire logic rd_active, // Sending
  input wire logic [ADDR_W-1:0] addr_ptr // Pointer
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence start_s; scl_i && $fell(sda_i); endsequence
  sequence stop_s; scl_i && $rose(sda_i); endsequence
  a_oe_clk_low: assert property (!$stable(sda_oe) |-> !scl_i) else $error("drive moved");
  a_drive_zero: assert property (sda_oe |-> !sda_o) else $error("drive high");
  a_end_release: assert property ($fell(rd_active) |-> !sda_oe) else $error("held after read");
  a_busy_ack: assert property (prog_busy && $past(prog_busy,4) && !rd_active |-> !$rose(sda_oe)) else $error("ack");
  a_busy_read: assert property (prog_busy && $past(prog_busy,4) |-> !$rose(rd_active)) else $error("read");
  a_ptr_step: assert property ($changed(addr_ptr) && rd_active |-> addr_ptr == $past(addr_ptr) + 1'b1) else $error("step");
  a_ptr_cause: assert property ($changed(addr_ptr) |-> rd_active || sda_oe) else $error("ptr moved");
  a_stop_release: assert property (stop_s |-> ##[1:8] (!rd_active && !sda_oe)) else $error("no release");
  a_start_idle: assert property (start_s |-> ##[1:8] !rd_active) else $error("start");
endmodule
bind sers_read_slave sers_read_slave_asserts #(.ADDR_W(ADDR_W)) sers_read_slave_asserts_inst (.clk(clk), .srst(srst),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .prog_busy(prog_busy), .rd_active(rd_active),
  .addr_ptr(addr_ptr));

// *** tb/sers_master_model.sv ***
`timescale 1ns/10ps
module sers_master_model (
  output logic scl, // Bus clock, idles high
  output logic sda_low, // Pulls data wire low
  input wire logic sda // Resolved wire
);
  localparam realtime Q = 31.25;
  initial scl = 1'b1;
  initial sda_low = 1'b0;
  // Data moves only a quarter period after the clock falls
  task automatic bit_x(input logic b, output logic r);
    sda_low = !b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
    #Q;
  endtask
  task automatic start_c();
    sda_low = 1'b0;
    #Q scl = 1'b1;
    #Q sda_low = 1'b1;
    #Q scl = 1'b0;
    #Q;
  endtask
  task automatic stop_c();
    sda_low = 1'b1;
    #Q scl = 1'b1;
    #Q sda_low = 1'b0;
    #Q;
  endtask
  task automatic tx(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(v[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask
  task automatic rx(input logic last, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      v[i] = r;
    end
    bit_x(last, r);
  endtask
endmodule

// *** tb/sers_read_slave_tb_top.sv ***
`timescale 1ns/10ps
`define CHK(n, e, v) begin cmp_count++; if ((v) !== (e)) begin mismatches++; $display("wrong value %s exp %h got %h", n, e, v); end end
module sers_read_slave_tb_top;
  logic clk, srst, scl, m_low, sda_o, sda_oe, supply_low, prog_busy, mem_we, rd_active, ack;
  logic [7:0] mem_waddr, mem_wdata, addr_ptr, d;
  logic [7:0] img [256];
  int mismatches, cmp_count, cyc;
  wire sda = !(sda_oe || m_low);
  sers_read_slave sers_read_slave_inst (.clk(clk), .srst(srst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .supply_low(supply_low), .prog_busy(prog_busy), .mem_we(mem_we), .mem_waddr(mem_waddr),
    .mem_wdata(mem_wdata), .rd_active(rd_active), .addr_ptr(addr_ptr));
  sers_master_model sers_master_model_inst (.scl(scl), .sda_low(m_low), .sda(sda));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      summarize();
    end
  end
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic poke(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    mem_we <= 1'b1;
    mem_waddr <= a;
    mem_wdata <= v;
    @(posedge clk);
    mem_we <= 1'b0;
  endtask
  task automatic hdr(input logic [7:0] c, input logic e);
    sers_master_model_inst.start_c();
    sers_master_model_inst.tx(c, ack);
    `CHK("ack", e, ack)
  endtask
  // Read n bytes from the pointer; last one left unacknowledged
  task automatic cur(input int n, input logic [7:0] a, input logic [7:0] c);
    hdr(c, 1'b1);
    for (int k = 0; k < n; k++) begin
      sers_master_model_inst.rx(k == n - 1, d);
      `CHK("data", img[8'(a + k)], d)
    end
    sers_master_model_inst.stop_c();
    `CHK("rd_active", 1'b0, rd_active)
    `CHK("sda_oe", 1'b0, sda_oe)
  endtask
  task automatic rread(input logic [7:0] a, input int n);
    hdr(8'ha0, 1'b1);
    sers_master_model_inst.tx(a, ack);
    `CHK("addr ack", 1'b1, ack)
    cur(n, a, 8'ha1);
  endtask
  initial begin
    {srst, supply_low, prog_busy, mem_we, mem_waddr, mem_wdata} = {4'h8, 16'h0000};
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 256; i++) begin
      img[i] = 8'(i) ^ 8'h5a;
      poke(8'(i), img[i]);
    end
    repeat (4) @(posedge clk);
    rread(8'hfe, 3);
    `CHK("pointer", 8'h01, addr_ptr)
    cur(1, 8'h01, 8'haf);
    hdr(8'hb1, 1'b0);
    sers_master_model_inst.stop_c();
    @(posedge clk);
    prog_busy <= 1'b1;
    hdr(8'ha1, 1'b0);
    sers_master_model_inst.stop_c();
    @(posedge clk);
    prog_busy <= 1'b0;
    supply_low <= 1'b1;
    repeat (4) @(posedge clk);
    poke(8'h10, 8'h00);
    supply_low <= 1'b0;
    rread(8'h10, 1);
    summarize();
  end
endmodule
